//--- ppgd_regs.vh
// Purpose: constants for the push-pull gate drive block
// Assumes: 50 MHz mclk, 20 ns period
// Notes:   times are in ns; cycle counts derive from them
`ifndef PPGD_REGS_VH
`define PPGD_REGS_VH

// ==========================================
// clock
`define PPGD_CLK_PERIOD_NS 20
`define PPGD_CLK_HZ        50000000

// ==========================================
// switching frequency variants, output frequency in Hz
`define PPGD_FSW_LOW_HZ  160000
`define PPGD_FSW_HIGH_HZ 424000

// ==========================================
// dead time, ns, as typical figures
`define PPGD_DEAD_LOW_NS  115
`define PPGD_DEAD_HIGH_NS 90

// ==========================================
// spread spectrum: triangle sweep of the oscillator half-period
`define PPGD_SS_SPAN    8'h10
`define PPGD_SS_STEP_HP 16'h0004

// ==========================================
// data channels: carrier-hold cycles before the receiver reads silence
`define PPGD_KEY_HOLD 2'h3

// ==========================================
// phase states
`define PPGD_ST_DEAD_A 2'h0
`define PPGD_ST_ON_A   2'h1
`define PPGD_ST_DEAD_B 2'h2
`define PPGD_ST_ON_B   2'h3

`endif

//--- ppgd_push_pull_gate_drive.v
// Purpose: two-phase gate drive for a push-pull transformer driver
// Assumes: one clock mclk at 50 MHz, async active-high reset
// Notes:   both gates low during reset; the first phase follows a dead time
`timescale 1ns/1ns
`include "ppgd_regs.vh"

module ppgd_push_pull_gate_drive
#(
	parameter HIGH_FREQ = 0,
	parameter SS_ENABLE = 1
)
(
	input  wire       mclk,
	input  wire       reset,
	output reg        firstOutputSwitch,
	output reg        secondOutputSwitch,
	output wire [1:0] drivePhase,
	input  wire [3:0] channelData,
	input  wire [3:0] barrierCarrier,
	output wire [3:0] keyedCarrier,
	output wire [3:0] recoveredData
);

	// ==========================================
	// derived timing
	localparam integer FSW_HZ = HIGH_FREQ ? `PPGD_FSW_HIGH_HZ
		: `PPGD_FSW_LOW_HZ;
	// oscillator runs at twice the output rate; halve it again for its half
	localparam integer OSC_HALF = `PPGD_CLK_HZ / (4 * FSW_HZ);
	localparam integer DEAD_NS = HIGH_FREQ ? `PPGD_DEAD_HIGH_NS
		: `PPGD_DEAD_LOW_NS;
	// least time: round up to whole cycles
	localparam integer DEAD_CYC_I = (DEAD_NS + `PPGD_CLK_PERIOD_NS - 1)
		/ `PPGD_CLK_PERIOD_NS;
	localparam [15:0] DEAD_CYC = DEAD_CYC_I[15:0];
	localparam [15:0] OSC_HALF_W = OSC_HALF[15:0];

	// ==========================================
	// spread spectrum sweep of oscillator half-period
	reg  [7:0]  ssPos_ff;
	reg         ssUp_ff;
	reg  [7:0]  nxt_ssPos;
	reg         nxt_ssUp;
	wire [15:0] oscHalf;

	assign oscHalf = SS_ENABLE
		? OSC_HALF_W + ({8'h00, ssPos_ff} >> 2)
		: OSC_HALF_W;

	// ==========================================
	// internal oscillator and divide-by-two
	reg  [15:0] oscCnt_ff;
	reg  [15:0] nxt_oscCnt;
	reg         osc_ff;
	reg         div_ff;
	reg         divPrev_ff;
	wire        oscRise;

	assign oscRise = (oscCnt_ff == oscHalf - 16'h0001) & ~osc_ff;

	// oscillator counter, sweep steps once per oscillator period
	always @*
	begin
		nxt_oscCnt = oscCnt_ff + 16'h0001;
		nxt_ssPos = ssPos_ff;
		nxt_ssUp = ssUp_ff;
		if (oscCnt_ff >= oscHalf - 16'h0001)
		begin
			nxt_oscCnt = 16'h0000;
			if (oscRise)
			begin
				if (ssUp_ff)
				begin
					nxt_ssPos = ssPos_ff + 8'h01;
					nxt_ssUp = (ssPos_ff + 8'h01) != `PPGD_SS_SPAN;
				end
				else
				begin
					nxt_ssPos = ssPos_ff - 8'h01;
					nxt_ssUp = (ssPos_ff - 8'h01) == 8'h00;
				end
			end
		end
	end

	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			oscCnt_ff <= 16'h0000;
			osc_ff <= 1'b0;
			div_ff <= 1'b0;
			divPrev_ff <= 1'b0;
			ssPos_ff <= 8'h00;
			ssUp_ff <= 1'b1;
		end
		else
		begin
			oscCnt_ff <= nxt_oscCnt;
			ssPos_ff <= nxt_ssPos;
			ssUp_ff <= nxt_ssUp;
			divPrev_ff <= div_ff;
			if (oscCnt_ff >= oscHalf - 16'h0001)
				osc_ff <= ~osc_ff;
			if (oscRise)
				div_ff <= ~div_ff;
		end
	end

	// ==========================================
	// dead-time insert and phase control
	// each divided half period: dead gap first, then on for the rest,
	// so both phases lose the same time and stay balanced
	reg  [1:0]  state_ff;
	reg  [1:0]  nxt_state;
	reg  [15:0] deadCnt_ff;
	reg  [15:0] nxt_deadCnt;
	wire        halfEdge;

	assign halfEdge = div_ff ^ divPrev_ff;
	assign drivePhase = state_ff;

	always @*
	begin
		nxt_state = state_ff;
		nxt_deadCnt = deadCnt_ff;
		case (state_ff)
			`PPGD_ST_DEAD_A, `PPGD_ST_DEAD_B:
			begin
				if (deadCnt_ff >= DEAD_CYC - 16'h0001)
				begin
					nxt_deadCnt = 16'h0000;
					nxt_state = (state_ff == `PPGD_ST_DEAD_A)
						? `PPGD_ST_ON_A : `PPGD_ST_ON_B;
				end
				else
					nxt_deadCnt = deadCnt_ff + 16'h0001;
			end
			`PPGD_ST_ON_A, `PPGD_ST_ON_B:
			begin
				nxt_deadCnt = 16'h0000;
				// divider is low after reset and A leads, so high selects B
				if (halfEdge) // swap every half period
					nxt_state = div_ff ? `PPGD_ST_DEAD_B : `PPGD_ST_DEAD_A;
			end
			default:
			begin
				nxt_state = `PPGD_ST_DEAD_A;
				nxt_deadCnt = 16'h0000;
			end
		endcase
	end

	// gate outputs registered; never both high by construction
	always @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state_ff <= `PPGD_ST_DEAD_A;
			deadCnt_ff <= 16'h0000;
			firstOutputSwitch <= 1'b0;
			secondOutputSwitch <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			deadCnt_ff <= nxt_deadCnt;
			firstOutputSwitch <= (nxt_state == `PPGD_ST_ON_A);
			secondOutputSwitch <= (nxt_state == `PPGD_ST_ON_B);
		end
	end

	// ==========================================
	// on-off keyed data channels
	// the carrier runs at half mclk; demodulation relies on the returning
	// carrier sharing mclk, a foreign clock at that rate would alias
	reg         carrier_ff;

	// free-running carrier shared by every channel
	always @(posedge mclk or posedge reset)
	begin
		if (reset)
			carrier_ff <= 1'b0;
		else
			carrier_ff <= ~carrier_ff;
	end

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1)
		begin : gChan
			reg        txMeta_ff;
			reg        txSync_ff;
			reg        txKey_ff;
			reg        rxMeta_ff;
			reg        rxSync_ff;
			reg        rxPrev_ff;
			reg        rxOut_ff;
			reg  [1:0] rxHold_ff;
			wire [1:0] nxt_rxHold;
			wire       rxEdge;

			// any carrier edge reloads the hold, silence drains it
			assign rxEdge = rxSync_ff ^ rxPrev_ff;
			assign nxt_rxHold = rxEdge ? `PPGD_KEY_HOLD
				: (rxHold_ff != 2'h0) ? rxHold_ff - 2'h1 : 2'h0;
			assign keyedCarrier[ch] = txKey_ff;
			assign recoveredData[ch] = rxOut_ff;

			// both pins pass two flops before keying or edge detect
			always @(posedge mclk or posedge reset)
			begin
				if (reset)
				begin
					txMeta_ff <= 1'b0;
					txSync_ff <= 1'b0;
					txKey_ff <= 1'b0;
					rxMeta_ff <= 1'b0;
					rxSync_ff <= 1'b0;
					rxPrev_ff <= 1'b0;
					rxOut_ff <= 1'b0;
					rxHold_ff <= 2'h0;
				end
				else
				begin
					txMeta_ff <= channelData[ch];
					txSync_ff <= txMeta_ff;
					txKey_ff <= txSync_ff & carrier_ff;
					rxMeta_ff <= barrierCarrier[ch];
					rxSync_ff <= rxMeta_ff;
					rxPrev_ff <= rxSync_ff;
					rxHold_ff <= nxt_rxHold;
					rxOut_ff <= (nxt_rxHold != 2'h0); // output buffer
				end
			end
		end
	endgenerate

endmodule // ppgd_push_pull_gate_drive

//--- ppgd_gate_assertions.sv
// Purpose: port checker for the gate drive
// Assumes: one clock, async reset
// Notes:   a counter keeps the dead run, so no long repetition
`timescale 1ns/1ns
module ppgd_gate_checker
#(parameter HIGH_FREQ = 0)
(
	input wire       mclk,
	input wire       reset,
	input wire       firstOutputSwitch,
	input wire       secondOutputSwitch,
	input wire [1:0] drivePhase
);
	localparam int DEAD = HIGH_FREQ ? 5 : 6;
	wire       a = firstOutputSwitch;
	wire       b = secondOutputSwitch;
	reg  [7:0] lowRun_ff;
	reg        lastA_ff;
	// ================
	// both-low run length and which gate was last on
	always @(posedge mclk or posedge reset)
	begin
		lowRun_ff <= (reset || a || b) ? 8'h00 : lowRun_ff + 8'h01;
		lastA_ff  <= reset ? 1'b0 : a ? 1'b1 : b ? 1'b0 : lastA_ff;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence riseA; $rose(a); endsequence
	sequence riseB; $rose(b); endsequence
	a_no_overlap: assert property (!(a && b))
		else $error("both gates on");
	a_phase_a: assert property (drivePhase == 2'h1 |-> a && !b)
		else $error("phase A gate mismatch");
	a_phase_b: assert property (drivePhase == 2'h3 |-> b && !a)
		else $error("phase B gate mismatch");
	a_dead_low: assert property (!drivePhase[0] |-> !a && !b)
		else $error("gate on in dead phase");
	a_dead_len: assert property ((riseA or riseB) |-> lowRun_ff >= DEAD)
		else $error("dead gap short");
	a_order_ab: assert property (riseA |-> !lastA_ff)
		else $error("first gate twice");
	a_order_ba: assert property (riseB |-> lastA_ff)
		else $error("second gate twice");
	a_fall_gap: assert property ($fell(a) |-> !b [*5])
		else $error("second gate too soon");
endmodule // ppgd_gate_checker
bind ppgd_push_pull_gate_drive ppgd_gate_checker #(.HIGH_FREQ(HIGH_FREQ))
	gateChk (.mclk(mclk), .reset(reset), .firstOutputSwitch(firstOutputSwitch),
	.secondOutputSwitch(secondOutputSwitch), .drivePhase(drivePhase));

//--- ppgd_xfmr_model.sv
// Purpose: center-tapped transformer behind two switches
// Assumes: gate high means switch on
// Notes:   flux counts first on-cycles minus second
`timescale 1ns/1ns
module ppgd_xfmr_model
(
	input wire     mclk,
	input wire     reset,
	input wire     gateA,
	input wire     gateB,
	output reg     shorted,
	output integer flux
);
	// both on shorts the primary; latched so a glitch is not lost
	always @(posedge mclk or posedge reset)
	begin
		flux    <= reset ? 0 : flux + gateA - gateB;
		shorted <= reset ? 1'b0 : shorted | (gateA & gateB);
	end
endmodule // ppgd_xfmr_model

//--- ppgd_push_pull_gate_drive_tb_top.sv
// Purpose: self-checking bench for the gate drive
// Assumes: low variant: 6 dead cycles, 150..158 on; high: 5 dead, 53 on
// Notes:   first A phase after reset is skipped, it may be short
`timescale 1ns/1ns
module ppgd_push_pull_gate_drive_tb_top;
	reg        mclk, reset;
	reg  [3:0] chData;
	reg  [7:0] k0;
	wire       gA, gB, shorted, gAH, gBH;
	wire [1:0] drivePhase;
	wire [3:0] keyed, keyedHi, rec, recHi;
	integer    flux, miscompares, samples_checked, n, onA, lo, hi, fluxStart;
	// keyed carrier loops straight back into the receiver pins
	ppgd_push_pull_gate_drive #(.HIGH_FREQ(0)) dut (.mclk(mclk),
		.reset(reset), .firstOutputSwitch(gA), .secondOutputSwitch(gB),
		.drivePhase(drivePhase), .channelData(chData),
		.barrierCarrier(keyed), .keyedCarrier(keyed), .recoveredData(rec));
	// high variant with the sweep off, so its spans are exact
	ppgd_push_pull_gate_drive #(.HIGH_FREQ(1), .SS_ENABLE(0)) dutHi (
		.mclk(mclk), .reset(reset), .firstOutputSwitch(gAH),
		.secondOutputSwitch(gBH), .drivePhase(), .channelData(chData),
		.barrierCarrier(keyedHi), .keyedCarrier(keyedHi),
		.recoveredData(recHi));
	ppgd_xfmr_model xfm (.mclk(mclk), .reset(reset), .gateA(gA),
		.gateB(gB), .shorted(shorted), .flux(flux));
	// ================
	// clock and shared tasks
	initial
	begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
	begin
		samples_checked = samples_checked + 1;
		if (e !== g)
		begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
		end
	end
	endtask
	task final_report;
	begin
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	// edges until gate sel reaches lvl, bounded
	task wait_gate(input logic [1:0] sel, input logic lvl);
	begin
		n = 0;
		while ((sel == 2'h0 ? gA : sel == 2'h1 ? gB : sel == 2'h2 ? gAH : gBH)
			!== lvl && n < 1000)
		begin
			@(posedge mclk);
			#1 n = n + 1;
		end
		chk("gate wait", 0, n >= 1000);
	end
	endtask
	task t_start;
	begin
		@(posedge mclk);
		#1 reset = 0;
		wait_gate(0, 1);
		chk("first rise", 16'h0006, n);
	end
	endtask
	task t_balance;
	begin
		lo = 999;
		hi = 0;
		wait_gate(0, 0);
		repeat (12)
		begin
			wait_gate(0, 1);
			if (lo == 999)
				fluxStart = flux;
			wait_gate(0, 0);
			onA = n;
			wait_gate(1, 1);
			chk("dead gap", 1, n >= 6);
			wait_gate(1, 0);
			chk("on span", 1, onA >= 150 && n >= 150 && n <= 158);
			chk("balance", 1, onA - n <= 4 && n - onA <= 4);
			lo = n < lo ? n : lo;
			hi = n > hi ? n : hi;
		end
		chk("spread", 1, hi > lo);
		chk("short", 0, shorted);
		chk("flux drift", 1, flux - fluxStart <= 16
			&& fluxStart - flux <= 16);
	end
	endtask
	// high variant: exact dead gap and equal on spans
	task t_high;
	begin
		wait_gate(3, 0);
		wait_gate(3, 1);
		wait_gate(3, 0);
		chk("high on B", 16'h0035, n);
		wait_gate(2, 1);
		chk("high dead", 16'h0005, n);
		wait_gate(2, 0);
		chk("high on A", 16'h0035, n);
	end
	endtask
	// keyed carrier out and recovered level back through the loop
	task t_chan;
	begin
		chData = 4'h5;
		repeat (12) @(posedge mclk);
		#1 k0 = {keyedHi, keyed};
		@(posedge mclk);
		#1 chk("carrier on", 16'h0055, {keyedHi, keyed} ^ k0);
		chk("recovered high", 16'h0055, {recHi, rec});
		chData = 4'h0;
		repeat (12) @(posedge mclk);
		#1 chk("carrier off", 16'h0000, {keyedHi, keyed});
		chk("recovered low", 16'h0000, {recHi, rec});
	end
	endtask
	// reset in the first cycle of a second-gate pulse
	task t_midreset;
	begin
		wait_gate(1, 1);
		reset = 1;
		#1 chk("reset gates", 0, {drivePhase, gA, gB});
		repeat (20) @(posedge mclk);
		t_start;
	end
	endtask
	initial
	begin
		miscompares = 0;
		samples_checked = 0;
		chData = 4'h0;
		reset = 1;
		repeat (20) @(posedge mclk);
		t_start;
		t_balance;
		t_high;
		t_chan;
		t_midreset;
		final_report;
	end
	// watchdog: about five times the expected run
	initial
	begin
		#400000;
		miscompares = miscompares + 1;
		final_report;
	end
endmodule // ppgd_push_pull_gate_drive_tb_top
